// ===== rtl/flash_map.vh
`ifndef FLASH_MAP_VH
`define FLASH_MAP_VH

// instruction codes
`define CMD_WRSR   8'h01
`define CMD_PP     8'h02
`define CMD_READ   8'h03
`define CMD_WRDI   8'h04
`define CMD_RDSR   8'h05
`define CMD_WREN   8'h06
`define CMD_FREAD  8'h0B
`define CMD_DREAD  8'h3B
`define CMD_SE     8'h20
`define CMD_HBE    8'h52
`define CMD_BE     8'hD8
`define CMD_CE_A   8'hC7
`define CMD_CE_B   8'h60

// status_and_protect layout
`define STAT_RESET  8'h00
`define STAT_LOCK   7
`define STAT_LVL_HI 4
`define STAT_LVL_LO 2

// array organisation
`define ADDR_W     20
`define MEM_BYTES  1048576
`define PAGE_BYTES 256
`define ERASED     8'hFF
`define PAGE_MASK   20'hFFF00
`define SECTOR_MASK 20'hFF000
`define HALF_MASK   20'hF8000
`define BLOCK_MASK  20'hF0000
`define PAGE_LEN    21'h000100
`define SECTOR_LEN  21'h001000
`define HALF_LEN    21'h008000
`define BLOCK_LEN   21'h010000
`define CHIP_LEN    21'h100000
`define SRW_LEN     21'h000010

// highest protected address per protect level
`define PROT_LIM_1 20'hFDFFF
`define PROT_LIM_2 20'hFBFFF
`define PROT_LIM_3 20'hF7FFF
`define PROT_LIM_4 20'hEFFFF
`define PROT_LIM_5 20'hDFFFF
`define PROT_LIM_6 20'hBFFFF

// embedded operation kinds
`define OP_PROG  2'h1
`define OP_ERASE 2'h2
`define OP_WAIT  2'h3

`endif

// ===== rtl/flash_array.v
`timescale 1ns/10ps
`include "flash_map.vh"

module flash_array (
  input  wire                 clk,
  input  wire                 rst,
  input  wire                 ce,
  input  wire [`ADDR_W-1:0]   rd_addr,
  output reg  [7:0]           rd_data,
  input  wire                 pb_clear,
  input  wire                 pb_we,
  input  wire [7:0]           pb_idx,
  input  wire [7:0]           pb_data,
  input  wire                 op_go,
  input  wire [1:0]           op_kind,
  input  wire [`ADDR_W-1:0]   op_base,
  input  wire [20:0]          op_len,
  output reg                  op_done
);

  reg [7:0]         mem [0:`MEM_BYTES-1];
  reg [7:0]         page_buf [0:`PAGE_BYTES-1];
  reg [255:0]       pb_valid;
  reg               running;
  reg [1:0]         kind;
  reg [`ADDR_W-1:0] ptr;
  reg [20:0]        left;
  integer           i;

  // parts leave the factory erased
  initial begin
    for (i = 0; i < `MEM_BYTES; i = i + 1) begin
      mem[i] = `ERASED;
    end
  end

  always @(posedge clk) begin
    if (ce) begin
      rd_data <= mem[rd_addr];
      if (pb_we) begin
        page_buf[pb_idx] <= pb_data;
      end
      if (running && kind == `OP_PROG && pb_valid[ptr[7:0]]) begin
        mem[ptr] <= mem[ptr] & page_buf[ptr[7:0]];
      end else if (running && kind == `OP_ERASE) begin
        mem[ptr] <= `ERASED;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      pb_valid <= 256'h0;
      running  <= 1'b0;
      kind     <= 2'h0;
      ptr      <= 20'h00000;
      left     <= 21'h000000;
      op_done  <= 1'b0;
    end else if (ce) begin
      op_done <= 1'b0;
      if (pb_clear) begin
        pb_valid <= 256'h0;
      end else if (pb_we) begin
        pb_valid[pb_idx] <= 1'b1;
      end
      if (op_go && !running) begin
        running <= 1'b1;
        kind    <= op_kind;
        ptr     <= op_base;
        left    <= op_len;
      end else if (running) begin
        ptr  <= ptr + 20'h00001;
        left <= left - 21'h000001;
        if (left == 21'h000001) begin
          running <= 1'b0;
          op_done <= 1'b1;
        end
      end
    end
  end

endmodule // flash_array

// ===== rtl/serial_flash_front.v
`timescale 1ns/10ps
`include "flash_map.vh"

module serial_flash_front (
  input  wire clk,
  input  wire rst,
  input  wire ce,
  input  wire spi_clk,
  input  wire cs_n,
  input  wire bidir_lane_zero_in,
  output reg  bidir_lane_zero_out,
  output reg  bidir_lane_zero_oe_n,
  output reg  output_lane_one_out,
  output reg  output_lane_one_oe_n,
  input  wire wp_n
);

  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_CMD    = 3'h1;
  localparam [2:0] ST_ADDR   = 3'h2;
  localparam [2:0] ST_DUMMY  = 3'h3;
  localparam [2:0] ST_READ   = 3'h4;
  localparam [2:0] ST_DATA   = 3'h5;
  localparam [2:0] ST_IGNORE = 3'h6;
  localparam [7:0] STAT_INIT = `STAT_RESET;

  function prot_hit;
    input [2:0]         level;
    input [`ADDR_W-1:0] a;
    begin
      case (level)
        3'h0:    prot_hit = 1'b0;
        3'h1:    prot_hit = (a <= `PROT_LIM_1);
        3'h2:    prot_hit = (a <= `PROT_LIM_2);
        3'h3:    prot_hit = (a <= `PROT_LIM_3);
        3'h4:    prot_hit = (a <= `PROT_LIM_4);
        3'h5:    prot_hit = (a <= `PROT_LIM_5);
        3'h6:    prot_hit = (a <= `PROT_LIM_6);
        default: prot_hit = 1'b1;
      endcase
    end
  endfunction

  reg [3:0]         sync1;
  reg [3:0]         sync2;
  reg [3:0]         sync3;
  reg [2:0]         state;
  reg [7:0]         cmd;
  reg [6:0]         shift_in;
  reg [2:0]         bit_cnt;
  reg [1:0]         addr_cnt;
  reg [1:0]         data_cnt;
  reg [`ADDR_W-1:0] addr;
  reg [`ADDR_W-1:0] rd_ptr;
  reg [7:0]         stat_data;
  reg [7:0]         out_byte;
  reg [2:0]         out_cnt;
  reg               dual;
  reg               armed;
  reg               status_lock_bit;
  reg [2:0]         array_protect_level;
  reg               write_enable_latch;
  reg               busy;
  reg               pb_clear;
  reg               pb_we;
  reg [7:0]         pb_idx;
  reg [7:0]         pb_data;
  reg               op_go;
  reg [1:0]         op_kind;
  reg [`ADDR_W-1:0] op_base;
  reg [20:0]        op_len;
  reg               c_ok;
  reg [1:0]         c_kind;
  reg [`ADDR_W-1:0] c_base;
  reg [20:0]        c_len;
  wire [7:0]        rd_data;
  wire              op_done;

  wire sclk_rise = sync2[3] & ~sync3[3];
  wire sclk_fall = ~sync2[3] & sync3[3];
  wire cs_high   = sync2[2];
  wire cs_fall   = ~sync2[2] & sync3[2];
  wire cs_rise   = sync2[2] & ~sync3[2];
  wire din       = sync2[1];
  wire wp_low    = ~sync2[0];
  wire [7:0] rx_byte = {shift_in, din};
  wire [7:0] status_word = {status_lock_bit, 2'b00, array_protect_level,
                            write_enable_latch, busy};
  wire [7:0] cur_byte = (out_cnt != 3'h0) ? out_byte :
                        (cmd == `CMD_RDSR) ? status_word : rd_data;

  // pins cross into clk through two flops; the third only feeds edge detect
  always @(posedge clk) begin
    if (rst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
    end else if (ce) begin
      sync1 <= {spi_clk, cs_n, bidir_lane_zero_in, wp_n};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // embedded operation that a finished frame would launch
  always @* begin
    c_ok   = 1'b0;
    c_kind = `OP_WAIT;
    c_base = addr;
    c_len  = `SRW_LEN;
    case (cmd)
      `CMD_WRSR: c_ok = (data_cnt != 2'h0) && !(status_lock_bit && wp_low);
      `CMD_PP: begin
        c_kind = `OP_PROG;
        c_base = addr & `PAGE_MASK;
        c_len  = `PAGE_LEN;
        c_ok   = (data_cnt != 2'h0) && !prot_hit(array_protect_level, addr);
      end
      `CMD_SE: begin
        c_kind = `OP_ERASE;
        c_base = addr & `SECTOR_MASK;
        c_len  = `SECTOR_LEN;
        c_ok   = (data_cnt == 2'h0) && !prot_hit(array_protect_level, c_base);
      end
      `CMD_HBE: begin
        c_kind = `OP_ERASE;
        c_base = addr & `HALF_MASK;
        c_len  = `HALF_LEN;
        c_ok   = (data_cnt == 2'h0) && !prot_hit(array_protect_level, c_base);
      end
      `CMD_BE: begin
        c_kind = `OP_ERASE;
        c_base = addr & `BLOCK_MASK;
        c_len  = `BLOCK_LEN;
        c_ok   = (data_cnt == 2'h0) && !prot_hit(array_protect_level, c_base);
      end
      `CMD_CE_A, `CMD_CE_B: begin
        c_kind = `OP_ERASE;
        c_base = 20'h00000;
        c_len  = `CHIP_LEN;
        c_ok   = (data_cnt == 2'h0) && (array_protect_level == 3'h0);
      end
      default: c_ok = 1'b0;
    endcase
    c_ok = c_ok & write_enable_latch & (bit_cnt == 3'h0) & (state == ST_DATA);
  end

  always @(posedge clk) begin
    if (rst) begin
      state                <= ST_IDLE;
      cmd                  <= 8'h00;
      shift_in             <= 7'h00;
      bit_cnt              <= 3'h0;
      addr_cnt             <= 2'h0;
      data_cnt             <= 2'h0;
      addr                 <= 20'h00000;
      rd_ptr               <= 20'h00000;
      stat_data            <= 8'h00;
      out_byte             <= 8'h00;
      out_cnt              <= 3'h0;
      dual                 <= 1'b0;
      armed                <= 1'b0;
      status_lock_bit      <= STAT_INIT[`STAT_LOCK];
      array_protect_level  <= STAT_INIT[`STAT_LVL_HI:`STAT_LVL_LO];
      write_enable_latch   <= 1'b0;
      busy                 <= 1'b0;
      pb_clear             <= 1'b0;
      pb_we                <= 1'b0;
      pb_idx               <= 8'h00;
      pb_data              <= 8'h00;
      op_go                <= 1'b0;
      op_kind              <= `OP_WAIT;
      op_base              <= 20'h00000;
      op_len               <= 21'h000000;
      bidir_lane_zero_out  <= 1'b0;
      bidir_lane_zero_oe_n <= 1'b1;
      output_lane_one_out  <= 1'b0;
      output_lane_one_oe_n <= 1'b1;
    end else if (ce) begin
      op_go    <= 1'b0;
      pb_clear <= 1'b0;
      pb_we    <= 1'b0;
      if (pb_we) begin
        pb_idx <= pb_idx + 8'h01;
      end
      if (cs_high) begin
        armed                <= 1'b1;
        state                <= ST_IDLE;
        bidir_lane_zero_oe_n <= 1'b1;
        output_lane_one_oe_n <= 1'b1;
        if (cs_rise && state == ST_DATA && bit_cnt == 3'h0 && data_cnt == 2'h0) begin
          if (cmd == `CMD_WREN) begin
            write_enable_latch <= 1'b1;
          end else if (cmd == `CMD_WRDI) begin
            write_enable_latch <= 1'b0;
          end
        end
        if (cs_rise && c_ok) begin
          op_go   <= 1'b1;
          op_kind <= c_kind;
          op_base <= c_base;
          op_len  <= c_len;
          busy    <= 1'b1;
          if (cmd == `CMD_WRSR) begin
            status_lock_bit     <= stat_data[`STAT_LOCK];
            array_protect_level <= stat_data[`STAT_LVL_HI:`STAT_LVL_LO];
          end
        end
      end else if (cs_fall && armed) begin
        state    <= ST_CMD;
        bit_cnt  <= 3'h0;
        out_cnt  <= 3'h0;
        addr_cnt <= 2'h0;
        data_cnt <= 2'h0;
        dual     <= 1'b0;
      end else if (state != ST_IDLE) begin
        if (sclk_rise && state != ST_READ) begin
          shift_in <= rx_byte[6:0];
          bit_cnt  <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            case (state)
              ST_CMD: begin
                cmd <= rx_byte;
                if (busy && rx_byte != `CMD_RDSR) begin
                  state <= ST_IGNORE;
                end else begin
                  case (rx_byte)
                    `CMD_RDSR: state <= ST_READ;
                    `CMD_READ, `CMD_FREAD, `CMD_DREAD, `CMD_SE, `CMD_HBE,
                    `CMD_BE: state <= ST_ADDR;
                    `CMD_PP: begin
                      state    <= ST_ADDR;
                      pb_clear <= 1'b1;
                    end
                    `CMD_WREN, `CMD_WRDI, `CMD_WRSR, `CMD_CE_A,
                    `CMD_CE_B: state <= ST_DATA;
                    default: state <= ST_IGNORE;
                  endcase
                end
              end
              ST_ADDR: begin
                addr     <= {addr[11:0], rx_byte};
                addr_cnt <= addr_cnt + 2'h1;
                if (addr_cnt == 2'h2) begin
                  rd_ptr <= {addr[11:0], rx_byte};
                  pb_idx <= rx_byte;
                  dual   <= (cmd == `CMD_DREAD);
                  case (cmd)
                    `CMD_READ: state <= ST_READ;
                    `CMD_FREAD, `CMD_DREAD: state <= ST_DUMMY;
                    default: state <= ST_DATA;
                  endcase
                end
              end
              ST_DUMMY: state <= ST_READ;
              ST_DATA: begin
                if (data_cnt == 2'h0) begin
                  stat_data <= rx_byte;
                end
                if (data_cnt != 2'h3) begin
                  data_cnt <= data_cnt + 2'h1;
                end
                if (cmd == `CMD_PP) begin
                  pb_we   <= 1'b1;
                  pb_data <= rx_byte;
                end
              end
              default: state <= state;
            endcase
          end
        end
        if (sclk_fall && state == ST_READ) begin
          output_lane_one_out  <= cur_byte[7];
          output_lane_one_oe_n <= 1'b0;
          bidir_lane_zero_out  <= cur_byte[6];
          bidir_lane_zero_oe_n <= ~dual;
          if (out_cnt == 3'h0 && cmd != `CMD_RDSR) begin
            rd_ptr <= rd_ptr + 20'h00001;
          end
          if (dual) begin
            out_byte <= {cur_byte[5:0], 2'b00};
            out_cnt  <= (out_cnt == 3'h3) ? 3'h0 : out_cnt + 3'h1;
          end else begin
            out_byte <= {cur_byte[6:0], 1'b0};
            out_cnt  <= out_cnt + 3'h1;
          end
        end
      end
      if (op_done) begin
        busy               <= 1'b0;
        write_enable_latch <= 1'b0;
      end
    end
  end

  flash_array u_array (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .rd_addr (rd_ptr),
    .rd_data (rd_data),
    .pb_clear(pb_clear),
    .pb_we   (pb_we),
    .pb_idx  (pb_idx),
    .pb_data (pb_data),
    .op_go   (op_go),
    .op_kind (op_kind),
    .op_base (op_base),
    .op_len  (op_len),
    .op_done (op_done)
  );

endmodule // serial_flash_front

// ===== tb/flash_front_assertions.sv
`timescale 1ns/10ps
module flash_front_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic bidir_lane_zero_in,
  input wire logic bidir_lane_zero_out,
  input wire logic bidir_lane_zero_oe_n,
  input wire logic output_lane_one_out,
  input wire logic output_lane_one_oe_n,
  input wire logic wp_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_float_one;
    cs_n [*6] |-> output_lane_one_oe_n;
  endproperty
  property p_float_zero;
    cs_n [*6] |-> bidir_lane_zero_oe_n;
  endproperty
  property p_hold_one;
    (spi_clk && !cs_n) [*3] |-> $stable({output_lane_one_out, output_lane_one_oe_n});
  endproperty
  property p_hold_zero;
    (spi_clk && !cs_n) [*3] |-> $stable({bidir_lane_zero_out, bidir_lane_zero_oe_n});
  endproperty
  property p_dual_pair;
    !bidir_lane_zero_oe_n |-> !output_lane_one_oe_n;
  endproperty
  property p_reset_idle;
    $fell(rst) |-> output_lane_one_oe_n && bidir_lane_zero_oe_n && !output_lane_one_out;
  endproperty
  property p_edge_one;
    $changed(output_lane_one_out) && !output_lane_one_oe_n && !$past(output_lane_one_oe_n)
      |-> !$past(spi_clk, 2);
  endproperty
  property p_edge_zero;
    $changed(bidir_lane_zero_out) && !bidir_lane_zero_oe_n && !$past(bidir_lane_zero_oe_n)
      |-> !$past(spi_clk, 2);
  endproperty
  a_float_one: assert property (p_float_one)
    else $error("lane one driven while deselected");
  a_float_zero: assert property (p_float_zero)
    else $error("lane zero driven while deselected");
  a_hold_one: assert property (p_hold_one)
    else $error("lane one moved without a falling clock");
  a_hold_zero: assert property (p_hold_zero)
    else $error("lane zero moved without a falling clock");
  a_dual_pair: assert property (p_dual_pair)
    else $error("lane zero driven outside a dual read");
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  a_edge_one: assert property (p_edge_one)
    else $error("lane one changed late after a rising clock");
  a_edge_zero: assert property (p_edge_zero)
    else $error("lane zero changed late after a rising clock");
  c_dual: cover property (!bidir_lane_zero_oe_n);
  c_read: cover property ($fell(output_lane_one_oe_n));
  c_mode3: cover property ($fell(cs_n) && spi_clk);
endmodule // flash_front_checker

bind serial_flash_front flash_front_checker u_chk (.clk(clk), .rst(rst), .ce(ce),
  .spi_clk(spi_clk), .cs_n(cs_n), .bidir_lane_zero_in(bidir_lane_zero_in),
  .bidir_lane_zero_out(bidir_lane_zero_out), .bidir_lane_zero_oe_n(bidir_lane_zero_oe_n),
  .output_lane_one_out(output_lane_one_out), .output_lane_one_oe_n(output_lane_one_oe_n),
  .wp_n(wp_n));

// ===== tb/spi_host.sv
`timescale 1ns/10ps
module spi_host (
  input  wire logic clk,
  input  wire logic out0,
  input  wire logic oe0_n,
  input  wire logic out1,
  input  wire logic oe1_n,
  output logic      spi_clk,
  output logic      cs_n,
  output wire logic lane0
);
  logic cpol  = 1'b0;
  logic d0    = 1'b0;
  logic hold1 = 1'b0;
  wire  l1;
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
  end
  // a released lane one shows the inverse of its last bit; a released lane zero carries d0
  assign lane0 = oe0_n ? d0 : out0;
  assign l1 = oe1_n ? ~hold1 : out1;
  always @(posedge clk) if (!oe1_n) hold1 <= out1;
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task start;
    spi_clk = cpol;
    tick(2);
    cs_n = 1'b0;
    tick(4);
  endtask
  task stop;
    if (!cpol) spi_clk = 1'b0;
    tick(4);
    cs_n = 1'b1;
    tick(8);
  endtask
  // read bits taken late in the high phase, the output lags each fall by sync latency
  task xb(input logic [7:0] o, input logic dual, output logic [7:0] r);
    int i;
    for (i = 7; i >= 0; i = i - (dual ? 2 : 1)) begin
      spi_clk = 1'b0;
      d0 = dual ? ~d0 : o[i];
      tick(4);
      spi_clk = 1'b1;
      tick(3);
      r = dual ? {r[5:0], l1, lane0} : {r[6:0], l1};
      tick(1);
    end
  endtask
endmodule // spi_host

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic clk  = 1'b0;
  logic rst  = 1'b1;
  logic wp_n = 1'b1;
  wire  spi_clk, cs_n, lane0, out0, oe0_n, out1, oe1_n;
  int   n_mismatch  = 0;
  int   check_count = 0;
  int   cycles      = 0;
  logic [7:0] r;
  initial forever #10 clk = ~clk;
  serial_flash_front u_dut (.clk(clk), .rst(rst), .ce(1'b1), .spi_clk(spi_clk), .cs_n(cs_n),
    .bidir_lane_zero_in(lane0), .bidir_lane_zero_out(out0), .bidir_lane_zero_oe_n(oe0_n),
    .output_lane_one_out(out1), .output_lane_one_oe_n(oe1_n), .wp_n(wp_n));
  spi_host u_host (.clk(clk), .out0(out0), .oe0_n(oe0_n), .out1(out1), .oe1_n(oe1_n),
    .spi_clk(spi_clk), .cs_n(cs_n), .lane0(lane0));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one frame: opcode, na address bytes, nd data bytes; r keeps the last byte read
  task op(input logic [7:0] c, input logic [23:0] a, input int na, input logic [7:0] d,
          input int nd, input logic dual);
    int i;
    u_host.start();
    u_host.xb(c, 1'b0, r);
    for (i = 2; i >= 3 - na; i--) u_host.xb(a[i*8 +: 8], 1'b0, r);
    for (i = 0; i < nd; i++) u_host.xb(d, dual && i > 0, r);
    u_host.stop();
  endtask
  task idle_wait;
    int k;
    for (k = 0; k < 60; k++) begin
      op(8'h05, 24'h0, 0, 8'h00, 1, 1'b0);
      if (r[0] === 1'b0) break;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    op(8'h05, 24'h0, 0, 8'h00, 1, 1'b0);
    chk(r, 8'h00);
    op(8'h02, 24'h0FFFFF, 3, 8'h5A, 1, 1'b0);
    op(8'h03, 24'h0FFFFF, 3, 8'hFF, 1, 1'b0);
    chk(r, 8'hFF);
    u_host.cpol = 1'b1;
    op(8'h06, 24'h0, 0, 8'h00, 0, 1'b0);
    op(8'h05, 24'h0, 0, 8'h00, 1, 1'b0);
    chk(r, 8'h02);
    op(8'h02, 24'h0FFFFF, 3, 8'h5A, 1, 1'b0);
    op(8'h05, 24'h0, 0, 8'h00, 1, 1'b0);
    chk(r, 8'h03);
    op(8'h06, 24'h0, 0, 8'h00, 0, 1'b0);
    idle_wait();
    chk(r, 8'h00);
    op(8'h06, 24'h0, 0, 8'h00, 0, 1'b0);
    op(8'h02, 24'h0FFFFF, 3, 8'hF0, 1, 1'b0);
    idle_wait();
    chk(r, 8'h00);
    u_host.cpol = 1'b0;
    op(8'h0B, 24'h0FFFFF, 3, 8'hFF, 2, 1'b0);
    chk(r, 8'h50);
    op(8'h3B, 24'h0FFFFF, 3, 8'hFF, 2, 1'b1);
    chk(r, 8'h50);
    op(8'h06, 24'h0, 0, 8'h00, 0, 1'b0);
    op(8'h01, 24'h0, 0, 8'hFC, 1, 1'b0);
    idle_wait();
    chk(r, 8'h9C);
    op(8'h06, 24'h0, 0, 8'h00, 0, 1'b0);
    op(8'h20, 24'h0FF123, 3, 8'h00, 0, 1'b0);
    op(8'h03, 24'h0FFFFF, 3, 8'hFF, 1, 1'b0);
    chk(r, 8'h50);
    wp_n = 1'b0;
    op(8'h01, 24'h0, 0, 8'h00, 1, 1'b0);
    idle_wait();
    chk(r, 8'h9E);
    wp_n = 1'b1;
    op(8'h01, 24'h0, 0, 8'h00, 1, 1'b0);
    idle_wait();
    chk(r, 8'h00);
    wp_n = 1'b0;
    op(8'h06, 24'h0, 0, 8'h00, 0, 1'b0);
    op(8'h01, 24'h0, 0, 8'h80, 1, 1'b0);
    idle_wait();
    chk(r, 8'h80);
    wp_n = 1'b1;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    op(8'h05, 24'h0, 0, 8'h00, 1, 1'b0);
    chk(r, 8'h00);
    op(8'h06, 24'h0, 0, 8'h00, 0, 1'b0);
    op(8'h20, 24'h0FF123, 3, 8'h00, 0, 1'b0);
    idle_wait();
    op(8'h03, 24'h0FF000, 3, 8'hFF, 1, 1'b0);
    chk(r, 8'hFF);
    op(8'h03, 24'h0FFFFF, 3, 8'hFF, 1, 1'b0);
    chk(r, 8'hFF);
    wrap_up();
  end
endmodule // tb
